// >>> core/ptc_pkg.sv
// Purpose: Shared constants and types of the positioning trigger block.
// Assumes: One 40 MHz clock, synchronous active-high reset.
// Notes:   Register indices are word indices; byte address is four times.

package ptc_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [3:0] PTC_IDX_MODE   = 4'h0;
    localparam logic [3:0] PTC_IDX_SET_LO = 4'h1;
    localparam logic [3:0] PTC_IDX_SET_HI = 4'h2;
    localparam logic [3:0] PTC_IDX_NUM    = 4'h3;
    localparam logic [3:0] PTC_IDX_DEN    = 4'h4;
    localparam logic [3:0] PTC_IDX_NUM2   = 4'h5;
    localparam logic [3:0] PTC_IDX_REF_HI = 4'h6;
    localparam logic [3:0] PTC_IDX_REF_LO = 4'h7;
    localparam logic [3:0] PTC_IDX_CNT_HI = 4'h8;
    localparam logic [3:0] PTC_IDX_CNT_LO = 4'h9;
    localparam logic [3:0] PTC_IDX_CTRL   = 4'ha;
    localparam logic [3:0] PTC_IDX_STATUS = 4'hb;

    // ------------------------------------------------------------------
    // Field layout and reset values
    // ------------------------------------------------------------------
    localparam int unsigned PTC_MODE_TRIG_BIT = 8;
    localparam int unsigned PTC_MODE_SRC_BIT  = 9;
    localparam int unsigned PTC_MODE_KEEP_BIT = 10;
    localparam logic [15:0] PTC_MODE_WMASK    = 16'h17ff;
    localparam logic [15:0] PTC_RATIO_RST     = 16'h03e8;
    localparam logic [15:0] PTC_REF_HI_MAX    = 16'h7530;
    localparam logic [15:0] PTC_REF_LO_MAX    = 16'hffff;
    localparam int unsigned PTC_CTRL_SEL2_BIT = 0;
    localparam logic [5:0]  PTC_DIV_STEPS     = 6'h30;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        PTC_ST_WAIT  = 2'b00,
        PTC_ST_SCALE = 2'b01,
        PTC_ST_MOVE  = 2'b11
    } ptc_state_t;

    typedef struct packed {
        logic a;
        logic b;
    } ptc_quad_t;

    // Byte-lane merge of a 16-bit register with Avalon write data.
    function automatic logic [15:0] ptc_merge(input logic [15:0] old,
                                              input logic [31:0] wd,
                                              input logic [3:0]  be);
        logic [15:0] r;
        r = old;
        if (be[0]) r[7:0] = wd[7:0];
        if (be[1]) r[15:8] = wd[15:8];
        return r;
    endfunction

endpackage

// >>> core/ptc_enable_sync.sv
// Purpose: Synchronise the positioning enable terminal, detect its edge.
// Assumes: Terminal is active high once it reaches this module.
// Notes:   The first stage is read only by the second stage.

`timescale 1ns/1ps

module ptc_enable_sync
    import ptc_pkg::*;
(
    // Clock and reset
    input  wire logic i_ref_clk,
    input  wire logic i_srst,
    input  wire logic i_ce,
    // Terminal
    input  wire logic i_pos_enable,
    // Detection
    output logic      o_rise,
    output logic      o_level
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } ptc_sync_t;

    ptc_sync_t q;
    ptc_sync_t d;

    always_comb
    begin
        d    = q;
        d.s1 = i_pos_enable;
        d.s2 = q.s1;
        d.s3 = q.s2;
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_srst)
            q <= '0;
        else if (i_ce)
            q <= d;
    end

    assign o_rise  = q.s2 & ~q.s3;
    assign o_level = q.s2;

endmodule

// >>> core/ptc_ratio_scale.sv
// Purpose: Scale a position by numerator over denominator, sequentially.
// Assumes: Denominator is never zero.
// Notes:   One quotient bit per enabled cycle; results saturate at 32 bits.

`timescale 1ns/1ps

module ptc_ratio_scale
    import ptc_pkg::*;
#(
    parameter int unsigned POS_W = 32,
    parameter int unsigned RAT_W = 16
)
(
    // Clock and reset
    input  wire logic             i_ref_clk,
    input  wire logic             i_srst,
    input  wire logic             i_ce,
    // Request
    input  wire logic             i_start,
    input  wire logic [POS_W-1:0] i_pos,
    input  wire logic [RAT_W-1:0] i_num,
    input  wire logic [RAT_W-1:0] i_den,
    // Result
    output logic                  o_done,
    output logic [POS_W-1:0]      o_result
);

    localparam int unsigned PW = POS_W + RAT_W;

    typedef struct packed {
        logic [5:0]       steps;
        logic [PW-1:0]    quot;
        logic [RAT_W:0]   rem;
        logic [RAT_W-1:0] den;
        logic             done;
        logic [POS_W-1:0] res;
    } ptc_div_t;

    ptc_div_t q;
    ptc_div_t d;

    always_comb
    begin
        logic [RAT_W:0] sh;
        sh     = '0;
        d      = q;
        d.done = 1'b0;
        if (i_start)
        begin
            // Restart wins over a division still in flight.
            d.quot  = PW'(i_pos * i_num);
            d.rem   = '0;
            d.den   = i_den;
            d.steps = PTC_DIV_STEPS;
        end
        else if (q.steps != 6'h00)
        begin
            sh     = {q.rem[RAT_W-1:0], q.quot[PW-1]};
            d.quot = {q.quot[PW-2:0], 1'b0};
            if (sh >= {1'b0, q.den})
            begin
                d.rem     = sh - {1'b0, q.den};
                d.quot[0] = 1'b1;
            end
            else
                d.rem = sh;
            d.steps = q.steps - 6'h01;
            if (q.steps == 6'h01)
            begin
                d.done = 1'b1;
                d.res  = (d.quot[PW-1:POS_W] != '0) ? '1
                                                    : d.quot[POS_W-1:0];
            end
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_srst)
            q <= '0;
        else if (i_ce)
            q <= d;
    end

    assign o_done   = q.done;
    assign o_result = q.res;

endmodule

// >>> core/ptc_top.sv
// Purpose: Positioning trigger, position source, reference and pulse count.
// Assumes: Pins are synchronous except the enable terminal; Avalon-MM slave.
// Notes:   Reading a low word freezes its high word for the next read.

`timescale 1ns/1ps

module ptc_top
    import ptc_pkg::*;
(
    // Clock, reset, clock enable
    input  wire logic        i_ref_clk,
    input  wire logic        i_srst,
    input  wire logic        i_ce,
    // Avalon-MM slave
    input  wire logic [5:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    input  wire logic [3:0]  i_avs_byteenable,
    output logic [31:0]      o_avs_readdata,
    output logic             o_avs_waitrequest,
    // Drive status
    input  wire logic        i_drive_run,
    input  wire logic        i_power_on,
    input  wire logic        i_pos_done,
    input  wire logic [31:0] i_bus_target,
    // Terminals
    input  wire logic        i_pos_enable,
    input  wire ptc_quad_t   i_pulse_cmd,
    // Positioning outputs
    output logic             o_pos_start,
    output logic             o_pos_busy,
    output logic [31:0]      o_pos_target,
    output logic [31:0]      o_pos_reference,
    output logic [31:0]      o_pulse_count,
    output logic             o_count_save
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        ptc_state_t  st;
        logic [15:0] positioning_mode_word;
        logic [15:0] digital_position_setting_low;
        logic [15:0] digital_position_setting_high;
        logic [15:0] command_ratio_numerator;
        logic [15:0] command_ratio_denominator;
        logic [15:0] second_command_ratio_numerator;
        logic        sel2;
        logic [31:0] target;
        logic [31:0] ref_val;
        logic [31:0] cnt;
        logic [31:0] keep;
        logic [15:0] shadow;
        logic        ack;
        logic [31:0] rdata;
        logic        start_p;
        logic        div_go;
        logic        save_p;
        logic        pwr_q;
        ptc_quad_t   quad;
    } ptc_core_t;

    ptc_core_t q;
    ptc_core_t d;

    logic        en_rise;
    logic        en_level;
    logic        div_done;
    logic [31:0] div_res;
    logic [15:0] num_sel;
    logic        req;
    logic [3:0]  idx;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------

    // Saturate a scaled position to the reportable reference range.
    function automatic logic [31:0] ptc_clamp_ref(input logic [31:0] v);
        logic [31:0] r;
        r = v;
        if (v[31:16] > PTC_REF_HI_MAX)
            r = {PTC_REF_HI_MAX, PTC_REF_LO_MAX};
        return r;
    endfunction

    // A ratio term of zero is refused; the register keeps its old value.
    function automatic logic [15:0] ptc_ratio_wr(input logic [15:0] old,
                                                 input logic [31:0] wd,
                                                 input logic [3:0]  be);
        logic [15:0] m;
        m = ptc_merge(old, wd, be);
        return (m == 16'h0000) ? old : m;
    endfunction

    // ------------------------------------------------------------------
    // Submodules
    // ------------------------------------------------------------------
    ptc_enable_sync u_enable_sync (
        .i_ref_clk    (i_ref_clk),
        .i_srst       (i_srst),
        .i_ce         (i_ce),
        .i_pos_enable (i_pos_enable),
        .o_rise       (en_rise),
        .o_level      (en_level)
    );

    assign num_sel = q.sel2 ? q.second_command_ratio_numerator
                            : q.command_ratio_numerator;

    ptc_ratio_scale #(
        .POS_W (32),
        .RAT_W (16)
    ) u_ratio_scale (
        .i_ref_clk (i_ref_clk),
        .i_srst    (i_srst),
        .i_ce      (i_ce),
        .i_start   (q.div_go),
        .i_pos     (q.target),
        .i_num     (num_sel),
        .i_den     (q.command_ratio_denominator),
        .o_done    (div_done),
        .o_result  (div_res)
    );

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    assign req = i_avs_read | i_avs_write;
    assign idx = i_avs_address[5:2];

    always_comb
    begin
        logic up;
        logic step;
        up        = q.quad.a ^ i_pulse_cmd.b;
        step      = (q.quad.a ^ i_pulse_cmd.a) ^ (q.quad.b ^ i_pulse_cmd.b);
        d         = q;
        d.start_p = 1'b0;
        d.div_go  = 1'b0;
        d.save_p  = 1'b0;
        d.pwr_q   = i_power_on;
        d.quad    = i_pulse_cmd;

        // Bus: read data is loaded in the first cycle, writes land when
        // waitrequest drops in the second.
        if (req && !q.ack)
        begin
            d.ack   = 1'b1;
            d.rdata = '0;
            if (i_avs_read)
            begin
                case (idx)
                    PTC_IDX_MODE:
                        d.rdata[15:0] = q.positioning_mode_word;
                    PTC_IDX_SET_LO:
                        d.rdata[15:0] = q.digital_position_setting_low;
                    PTC_IDX_SET_HI:
                        d.rdata[15:0] = q.digital_position_setting_high;
                    PTC_IDX_NUM:
                        d.rdata[15:0] = q.command_ratio_numerator;
                    PTC_IDX_DEN:
                        d.rdata[15:0] = q.command_ratio_denominator;
                    PTC_IDX_NUM2:
                        d.rdata[15:0] = q.second_command_ratio_numerator;
                    PTC_IDX_REF_HI:
                        d.rdata[15:0] = q.shadow;
                    PTC_IDX_REF_LO:
                    begin
                        d.rdata[15:0] = q.ref_val[15:0];
                        d.shadow      = q.ref_val[31:16];
                    end
                    PTC_IDX_CNT_HI:
                        d.rdata[15:0] = q.shadow;
                    PTC_IDX_CNT_LO:
                    begin
                        d.rdata[15:0] = q.cnt[15:0];
                        d.shadow      = q.cnt[31:16];
                    end
                    PTC_IDX_CTRL:
                        d.rdata[PTC_CTRL_SEL2_BIT] = q.sel2;
                    PTC_IDX_STATUS:
                        d.rdata[3:0] = {i_power_on, en_level, q.st};
                    default:
                        d.rdata = '0;
                endcase
            end
        end
        else if (q.ack)
        begin
            d.ack = 1'b0;
            if (i_avs_write)
            begin
                case (idx)
                    PTC_IDX_MODE:
                        d.positioning_mode_word = ptc_merge(
                            q.positioning_mode_word, i_avs_writedata,
                            i_avs_byteenable) & PTC_MODE_WMASK;
                    PTC_IDX_SET_LO:
                        d.digital_position_setting_low = ptc_merge(
                            q.digital_position_setting_low,
                            i_avs_writedata, i_avs_byteenable);
                    PTC_IDX_SET_HI:
                        d.digital_position_setting_high = ptc_merge(
                            q.digital_position_setting_high,
                            i_avs_writedata, i_avs_byteenable);
                    PTC_IDX_NUM:
                        d.command_ratio_numerator = ptc_ratio_wr(
                            q.command_ratio_numerator,
                            i_avs_writedata, i_avs_byteenable);
                    PTC_IDX_DEN:
                        d.command_ratio_denominator = ptc_ratio_wr(
                            q.command_ratio_denominator,
                            i_avs_writedata, i_avs_byteenable);
                    PTC_IDX_NUM2:
                        d.second_command_ratio_numerator = ptc_ratio_wr(
                            q.second_command_ratio_numerator,
                            i_avs_writedata, i_avs_byteenable);
                    PTC_IDX_CTRL:
                        if (i_avs_byteenable[0])
                            d.sel2 = i_avs_writedata[PTC_CTRL_SEL2_BIT];
                    default:
                        d.ack = 1'b0;
                endcase
            end
        end

        // Positioning sequence. An edge seen while a move is under way is
        // dropped on purpose; in level mode a held terminal restarts at
        // once after each completion.
        case (q.st)
            PTC_ST_WAIT:
                if (i_drive_run &&
                    (q.positioning_mode_word[PTC_MODE_TRIG_BIT] ? en_level
                                                                : en_rise))
                begin
                    d.target = q.positioning_mode_word[PTC_MODE_SRC_BIT]
                             ? i_bus_target
                             : {q.digital_position_setting_high,
                                q.digital_position_setting_low};
                    d.div_go  = 1'b1;
                    d.start_p = 1'b1;
                    d.st      = PTC_ST_SCALE;
                end
            PTC_ST_SCALE:
                if (div_done)
                begin
                    d.ref_val = ptc_clamp_ref(div_res);
                    d.st      = PTC_ST_MOVE;
                end
            PTC_ST_MOVE:
                if (i_pos_done)
                    d.st = PTC_ST_WAIT;
            default:
                d.st = PTC_ST_WAIT;
        endcase

        // A stop aborts the sequence and clears the reference.
        if (!i_drive_run)
        begin
            d.ref_val = '0;
            d.st      = PTC_ST_WAIT;
        end

        // Pulse count runs only with power; power loss saves or drops it.
        if (i_power_on)
        begin
            if (!q.pwr_q)
                d.cnt = q.keep;
            else if (step)
                d.cnt = up ? q.cnt + 32'h0000_0001
                           : q.cnt - 32'h0000_0001;
        end
        else if (q.pwr_q)
        begin
            if (q.positioning_mode_word[PTC_MODE_KEEP_BIT])
            begin
                d.keep   = q.cnt;
                d.save_p = 1'b1;
            end
            else
                d.keep = '0;
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge i_ref_clk)
    begin
        if (i_srst)
        begin
            q                                <= '0;
            q.command_ratio_numerator        <= PTC_RATIO_RST;
            q.command_ratio_denominator      <= PTC_RATIO_RST;
            q.second_command_ratio_numerator <= PTC_RATIO_RST;
        end
        else if (i_ce)
            q <= d;
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Waitrequest also covers a frozen clock enable, so no access can
    // complete while its write would be lost.
    assign o_avs_waitrequest = req & ~(q.ack & i_ce);
    assign o_avs_readdata    = q.rdata;
    assign o_pos_start       = q.start_p;
    assign o_pos_busy        = (q.st != PTC_ST_WAIT);
    assign o_pos_target      = q.target;
    assign o_pos_reference   = q.ref_val;
    assign o_pulse_count     = q.cnt;
    assign o_count_save      = q.save_p;

endmodule

// >>> dv/ptc_top_monitor.sv
// Purpose: Port-level checks of the positioning trigger block.
// Assumes: Single clock domain, synchronous active-high reset.
// Notes:   Attached to every ptc_top instance by the bind at the foot.

`timescale 1ns/1ps

module ptc_top_monitor
    import ptc_pkg::*;
(
    // Clock and reset
    input  wire logic        i_ref_clk,
    input  wire logic        i_srst,
    input  wire logic        i_ce,
    // Register bus
    input  wire logic [5:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    input  wire logic [3:0]  i_avs_byteenable,
    input  wire logic [31:0] o_avs_readdata,
    input  wire logic        o_avs_waitrequest,
    // Drive status and terminals
    input  wire logic        i_drive_run,
    input  wire logic        i_power_on,
    input  wire logic        i_pos_done,
    input  wire logic [31:0] i_bus_target,
    input  wire logic        i_pos_enable,
    input  wire ptc_quad_t   i_pulse_cmd,
    // Positioning outputs
    input  wire logic        o_pos_start,
    input  wire logic        o_pos_busy,
    input  wire logic [31:0] o_pos_target,
    input  wire logic [31:0] o_pos_reference,
    input  wire logic [31:0] o_pulse_count,
    input  wire logic        o_count_save
);
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_srst);

    sequence s_req_waiting;
        (i_avs_read || i_avs_write) && o_avs_waitrequest && i_ce;
    endsequence
    sequence s_req_held;
        (i_avs_read || i_avs_write) && i_ce;
    endsequence

    chk_bus_one_wait: assert property (s_req_waiting ##1 s_req_held
        |-> !o_avs_waitrequest) else $error("bus answer late");
    chk_single_ack: assert property ((s_req_held and !o_avs_waitrequest)
        |=> ((i_avs_read || i_avs_write) |-> o_avs_waitrequest))
        else $error("bus answered twice");
    chk_read_upper: assert property (!o_avs_waitrequest
        |-> o_avs_readdata[31:16] == 16'h0) else $error("upper bits set");
    chk_start_busy: assert property (o_pos_start |-> o_pos_busy)
        else $error("start without busy");
    chk_start_run: assert property (o_pos_start |-> $past(i_drive_run))
        else $error("start while stopped");
    chk_start_single: assert property (o_pos_start |=> !o_pos_start)
        else $error("start longer than one cycle");
    chk_stop_clears: assert property (!i_drive_run && i_ce
        |=> o_pos_reference == 32'h0 && !o_pos_busy)
        else $error("reference kept after stop");
    chk_ref_clamp: assert property (o_pos_reference[31:16] <= 16'h7530)
        else $error("reference high word above limit");
    chk_save_pulse: assert property (o_count_save
        |-> !$past(i_power_on) ##1 !o_count_save)
        else $error("count save out of place");
    chk_count_frozen: assert property (!$past(i_power_on)
        |-> $stable(o_pulse_count)) else $error("count moved while off");
endmodule

bind ptc_top ptc_top_monitor ptc_top_monitor_i (.*);

// >>> dv/ptc_field_model.sv
// Purpose: Far side: positioning enable terminal and quadrature pulse pair.
// Assumes: Commands come from the bench just after rising edges.
// Notes:   One quadrature state change per edge that sees a step.

`timescale 1ns/1ps

module ptc_field_model
    import ptc_pkg::*;
(
    // Clock
    input  wire logic i_ref_clk,
    // Commands from the bench
    input  wire logic i_enable,
    input  wire logic i_step,
    input  wire logic i_up,
    // Terminals
    output ptc_quad_t o_pulse_cmd,
    output logic      o_pos_enable
);
    logic [1:0] phase_q = 2'h0;

    always @(posedge i_ref_clk)
    begin
        if (i_step)
            phase_q <= i_up ? phase_q + 2'h1 : phase_q - 2'h1;
    end

    // Gray order 00, 01, 11, 10 is the upward direction.
    assign o_pulse_cmd.a = phase_q[1];
    assign o_pulse_cmd.b = phase_q[1] ^ phase_q[0];
    assign o_pos_enable  = i_enable;
endmodule

// >>> dv/tb_top.sv
// Purpose: Self-checking bench of the positioning trigger block.
// Assumes: 40 MHz clock; all inputs driven by non-blocking assignment.
// Notes:   Bus waits are bounded; a spent bound ends the run as a failure.

`timescale 1ns/1ps

module tb_top
    import ptc_pkg::*;
;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [5:0]  addr = 6'h0;
    logic [31:0] wdata = 32'h0;
    logic        run = 1'b0;
    logic        power = 1'b0;
    logic        done = 1'b0;
    logic [31:0] bus_target = 32'h0;
    logic        en = 1'b0;
    logic        step = 1'b0;
    logic        up = 1'b0;
    logic [31:0] rdata;
    logic        waitreq;
    logic        pos_en;
    ptc_quad_t   pulse_cmd;
    logic        start;
    logic        busy;
    logic [31:0] target;
    logic [31:0] reference;
    logic [31:0] count;
    logic        save;
    int          miscompares = 0;
    int          n_checks = 0;
    int          k;

    always #12.5 clk = ~clk;

    ptc_top ptc_top_i (.i_ref_clk(clk), .i_srst(srst), .i_ce(1'b1),
        .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
        .i_avs_writedata(wdata), .i_avs_byteenable(4'h3),
        .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq),
        .i_drive_run(run), .i_power_on(power), .i_pos_done(done),
        .i_bus_target(bus_target), .i_pos_enable(pos_en),
        .i_pulse_cmd(pulse_cmd), .o_pos_start(start), .o_pos_busy(busy),
        .o_pos_target(target), .o_pos_reference(reference),
        .o_pulse_count(count), .o_count_save(save));

    ptc_field_model ptc_field_model_i (.i_ref_clk(clk), .i_enable(en),
        .i_step(step), .i_up(up), .o_pulse_cmd(pulse_cmd),
        .o_pos_enable(pos_en));

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // A spent bound means the design never answered; stop here.
    task automatic give_up(input int n);
        if (n >= 80)
        begin
            miscompares++;
            print_verdict();
        end
    endtask

    task automatic bus(input logic w, input logic [5:0] a,
                       input logic [15:0] d, output logic [31:0] q);
        int n;
        @(posedge clk);
        rd <= !w;
        wr <= w;
        addr <= a;
        wdata <= {16'h0, d};
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (waitreq !== 1'b0 && n < 80);
        give_up(n);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    task automatic wreg(input logic [5:0] a, input logic [15:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rchk(input logic [5:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 16'h0, q);
        check(q, exp);
    endtask

    task automatic wait_pulse(input logic sel);
        int n;
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
        end
        while ((sel ? save : start) !== 1'b1 && n < 80);
        give_up(n);
        @(posedge clk);
    endtask

    task automatic steps(input int n, input logic u);
        repeat (n)
        begin
            @(posedge clk);
            step <= 1'b1;
            up <= u;
        end
        @(posedge clk);
        step <= 1'b0;
        repeat (4) @(posedge clk);
    endtask

    initial
    begin
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        // ------------------------------------------------------------
        // Reset values and access kinds
        // ------------------------------------------------------------
        rchk(6'h04, 32'h0);
        rchk(6'h14, 32'h3e8);
        rchk(6'h0c, 32'h3e8);
        rchk(6'h1c, 32'h0);
        rchk(6'h18, 32'h0);
        rchk(6'h24, 32'h0);
        rchk(6'h20, 32'h0);
        wreg(6'h00, 16'hffff);
        rchk(6'h00, 32'h17ff);
        wreg(6'h00, 16'h0000);
        wreg(6'h1c, 16'h1234);
        rchk(6'h1c, 32'h0);
        rchk(6'h30, 32'h0);
        wreg(6'h14, 16'h0000);
        rchk(6'h14, 32'h3e8);
        wreg(6'h04, 16'hffff);
        rchk(6'h04, 32'hffff);
        $display("test registers done");
        // ------------------------------------------------------------
        // Edge then level triggering
        // ------------------------------------------------------------
        wreg(6'h04, 16'h0064);
        run <= 1'b1;
        en <= 1'b1;
        wait_pulse(1'b0);
        check(target, 32'h64);
        repeat (60) @(posedge clk);
        check(reference, 32'h64);
        rchk(6'h1c, 32'h64);
        rchk(6'h18, 32'h0);
        done <= 1'b1;
        @(posedge clk);
        done <= 1'b0;
        k = 0;
        repeat (30)
        begin
            @(negedge clk);
            if (start === 1'b1)
                k++;
        end
        check(k, 32'h0);
        wreg(6'h00, 16'h0100);
        wait_pulse(1'b0);
        $display("test trigger done");
        // ------------------------------------------------------------
        // Stop clears, fieldbus source, saturation
        // ------------------------------------------------------------
        run <= 1'b0;
        repeat (3) @(posedge clk);
        check(reference, 32'h0);
        wreg(6'h00, 16'h0300);
        wreg(6'h10, 16'h0001);
        bus_target <= 32'h7fffffff;
        run <= 1'b1;
        wait_pulse(1'b0);
        check(target, 32'h7fffffff);
        repeat (60) @(posedge clk);
        check(reference, 32'h7530ffff);
        rchk(6'h1c, 32'hffff);
        rchk(6'h18, 32'h7530);
        run <= 1'b0;
        $display("test source done");
        // ------------------------------------------------------------
        // Pulse count and retention over power-off
        // ------------------------------------------------------------
        power <= 1'b1;
        steps(5, 1'b1);
        steps(2, 1'b0);
        check(count, 32'h3);
        rchk(6'h24, 32'h3);
        rchk(6'h20, 32'h0);
        wreg(6'h00, 16'h0400);
        power <= 1'b0;
        wait_pulse(1'b1);
        steps(4, 1'b1);
        power <= 1'b1;
        repeat (4) @(posedge clk);
        check(count, 32'h3);
        wreg(6'h00, 16'h0000);
        power <= 1'b0;
        repeat (4) @(posedge clk);
        power <= 1'b1;
        repeat (4) @(posedge clk);
        check(count, 32'h0);
        $display("test count done");
        print_verdict();
    end
endmodule
